// file: src/tpc_pkg.sv
// shared constants and carriers for the two-channel pwm timer
`default_nettype none
package tpc_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 6;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [5:0] PRE_RST = 6'h00;
  localparam logic [2:0] PS_DIV1 = 3'h0;
  localparam logic [2:0] PS_EXT = 3'h7;
  localparam logic [1:0] ELS_NONE = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic wrap_flag;
    logic wrap_irq_enable;
    logic counter_halt;
    logic counter_clear;
    logic [2:0] prescale_select;
  } tpc_tmr_ctl_s;

  typedef struct packed {
    logic event_flag;
    logic irq_enable;
    logic buffer_link;
    logic unbuffered_select;
    logic level_select_hi;
    logic level_select_lo;
    logic toggle_on_wrap;
    logic full_duty;
  } tpc_chan_ctl_s;

  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } tpc_wr16_s;

  // counter halted out of reset
  localparam tpc_tmr_ctl_s TMR_CTL_RST = 7'b0010000;
  localparam tpc_chan_ctl_s CHAN_CTL_RST = 8'h00;

endpackage : tpc_pkg
`default_nettype wire

// file: src/tpc_prescaler.sv
// counter clock enable: bus clock divider or external clock pin edge
`timescale 1ns/100ps
`default_nettype none
module tpc_prescaler
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic run,
  input wire logic [2:0] ps,
  input wire logic ext_pin,
  // counter enable
  output logic tick
);

  logic [5:0] pre_ff;
  logic ext_prev_ff;

  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    div_mask = 6'((7'h01 << sel) - 7'h01);
  endfunction : div_mask

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= PRE_RST;
    end else if (clr) begin
      pre_ff <= PRE_RST;
    end else if (run) begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  // pin is synchronous; edge seen only while running so a halt drops no state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_ff <= 1'b0;
    end else if (run) begin
      ext_prev_ff <= ext_pin;
    end
  end

  always_comb begin
    if (!run || clr) begin
      tick = 1'b0;
    end else if (ps == PS_EXT) begin
      tick = ext_pin && !ext_prev_ff;
    end else begin
      tick = (pre_ff & div_mask(ps)) == div_mask(ps);
    end
  end

endmodule : tpc_prescaler
`default_nettype wire

// file: src/tpc_pwm_pair.sv
// two-channel 16-bit timer with unbuffered and buffered pwm outputs
//
// Function
// - toggle-on-wrap flips the pin at each modulo wrap, setting the period
// - pulse ends at compare match measured from the wrap
// - modulo 255 with divide-by-1 gives a 256-clock period
// - compare 128 in a 256 period gives 50 percent duty
// - unbuffered compare value takes effect immediately
// - buffer link joins both channels onto the channel-0 pin, channel 0 first
// - buffered: last written compare pair controls from each next wrap
// - linked: channel-0 control rules, channel-1 control unused, pin freed
// - mode 0:1 unbuffered, 1:0 buffered; link bit has priority
// - level select 1:0 clears, 1:1 sets the pin on compare
// - toggle-on-wrap off gives no wrap toggle, so 0 percent duty
// - full duty with toggle-on-wrap off gives constant 100 percent
// - wrap flag set on wrap; wrap interrupt when enabled
// - channel flag set on each compare; interrupt only when enabled
// - wait mode: timer runs, registers closed, interrupts wake
// - stop mode: timer frozen, state kept, resumes afterwards
// - break halts the counter and so suppresses compare events
// - break clear enable low protects flags; high lets clears stick
// - prescale select picks divide 1 to 64 or the external clock pin
// - counter restarts from zero on the tick after reaching modulo
// - counter clear resets counter and prescaler, self-clears, reads 0
// - halt holds the counter; set at reset
`timescale 1ns/100ps
`default_nettype none
module tpc_pwm_pair
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // system states
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_state,
  input wire logic break_clear_enable,
  // timer status and control access
  input wire logic tmr_ctl_rd,
  input wire logic tmr_ctl_wr,
  input wire tpc_tmr_ctl_s tmr_ctl_wdata,
  // channel status and control access
  input wire logic [1:0] chan_ctl_rd,
  input wire logic [1:0] chan_ctl_wr,
  input wire tpc_chan_ctl_s chan0_ctl_wdata,
  input wire tpc_chan_ctl_s chan1_ctl_wdata,
  // modulo and compare writes
  input wire tpc_wr16_s mod_wr,
  input wire tpc_wr16_s cmp0_wr,
  input wire tpc_wr16_s cmp1_wr,
  // external timer clock pin
  input wire logic ext_timer_clock_pin,
  // readback
  output tpc_tmr_ctl_s tmr_ctl_q,
  output tpc_chan_ctl_s chan0_ctl_q,
  output tpc_chan_ctl_s chan1_ctl_q,
  output logic [15:0] counter_q,
  output logic [15:0] mod_q,
  output logic [15:0] cmp0_q,
  output logic [15:0] cmp1_q,
  // channel pins
  output logic chan0_pin_o,
  output logic chan0_pin_oe,
  output logic chan1_pin_o,
  output logic chan1_pin_oe,
  // interrupt requests
  output logic wrap_irq,
  output logic chan0_irq,
  output logic chan1_irq,
  output logic wake_req
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  tpc_tmr_ctl_s tmr_ff;
  tpc_chan_ctl_s ch_ff [2];
  logic [15:0] cnt_ff, mod_ff, cmp0_ff, cmp1_ff;
  logic wrap_flag_ff, wrap_arm_ff;
  logic [1:0] ch_flag_ff, ch_arm_ff;
  logic act_ff, last_ff;
  logic [1:0] pin_ff, oe_ff;
  logic wrap_irq_ff, wake_ff;
  logic [1:0] ch_irq_ff;

  logic acc_ok, run, clr_req, tick, wrap_evt, flag_ok;
  logic link, oc0, oc1, nxt_last;
  logic [15:0] nxt_cnt, act_cmp;
  logic [1:0] cmp_evt;
  logic [1:0] nxt_wrap_st, nxt_ch0_st, nxt_ch1_st;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // returns {flag, arm}; a new event beats a clear and disarms it
  function automatic logic [1:0] flag_step(input logic flag, input logic arm,
                                           input logic set, input logic rd,
                                           input logic wr0, input logic ok);
    if (set) begin
      flag_step = 2'b10;
    end else if (ok && wr0 && arm && flag) begin
      flag_step = 2'b00;
    end else if (ok && rd && flag) begin
      flag_step = 2'b11;
    end else begin
      flag_step = {flag, arm};
    end
  endfunction : flag_step

  function automatic logic pin_step(input logic pin, input tpc_chan_ctl_s c,
                                    input logic wrap, input logic cmp);
    logic p;
    p = pin;
    if (c.full_duty && !c.toggle_on_wrap) begin
      p = !c.level_select_lo;
    end else begin
      if (wrap && c.toggle_on_wrap) begin
        p = !p;
      end
      // full duty masks the compare, so only the wrap toggle moves the pin
      if (cmp && !c.full_duty) begin
        unique case ({c.level_select_hi, c.level_select_lo})
          ELS_CLEAR: p = 1'b0;
          ELS_SET: p = 1'b1;
          ELS_TOGGLE: p = !p;
          ELS_NONE: p = pin;
        endcase
      end
    end
    pin_step = p;
  endfunction : pin_step

  //////////////////////////////////////////////////////////////////////////////
  // access gating and counter clock

  assign acc_ok = !wait_mode && !stop_mode;
  assign run = !stop_mode && !break_state && !tmr_ff.counter_halt;
  assign clr_req = acc_ok && tmr_ctl_wr && tmr_ctl_wdata.counter_clear;
  assign flag_ok = !break_state || break_clear_enable;

  tpc_prescaler u_pre (
    .clk(clk),
    .rst(rst),
    .clr(clr_req),
    .run(run),
    .ps(tmr_ff.prescale_select),
    .ext_pin(ext_timer_clock_pin),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  // clear bit is never stored, so it always reads back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_ff <= TMR_CTL_RST;
    end else if (acc_ok && tmr_ctl_wr) begin
      tmr_ff.wrap_irq_enable <= tmr_ctl_wdata.wrap_irq_enable;
      tmr_ff.counter_halt <= tmr_ctl_wdata.counter_halt;
      tmr_ff.prescale_select <= tmr_ctl_wdata.prescale_select;
    end
  end

  // link bit exists only on channel 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_ff[0] <= CHAN_CTL_RST;
      ch_ff[1] <= CHAN_CTL_RST;
    end else begin
      if (acc_ok && chan_ctl_wr[0]) begin
        ch_ff[0] <= chan0_ctl_wdata;
      end
      if (acc_ok && chan_ctl_wr[1]) begin
        ch_ff[1] <= chan1_ctl_wdata;
        ch_ff[1].buffer_link <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_ff <= MOD_RST;
      cmp0_ff <= CMP_RST;
      cmp1_ff <= CMP_RST;
    end else if (acc_ok) begin
      if (mod_wr.wr) begin
        mod_ff <= mod_wr.data;
      end
      if (cmp0_wr.wr) begin
        cmp0_ff <= cmp0_wr.data;
      end
      if (cmp1_wr.wr) begin
        cmp1_ff <= cmp1_wr.data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter

  assign wrap_evt = tick && (cnt_ff == mod_ff);

  always_comb begin
    if (clr_req) begin
      nxt_cnt = CNT_RST;
    end else if (wrap_evt) begin
      nxt_cnt = CNT_RST;
    end else if (tick) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffered pair selection

  assign link = ch_ff[0].buffer_link;
  assign oc0 = link || ch_ff[0].unbuffered_select;
  assign oc1 = !link && ch_ff[1].unbuffered_select;

  always_comb begin
    nxt_last = last_ff;
    if (acc_ok && cmp0_wr.wr) begin
      nxt_last = 1'b0;
    end
    if (acc_ok && cmp1_wr.wr) begin
      nxt_last = 1'b1;
    end
  end

  // pair written last takes over only at a wrap, so a period is never cut
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (!link) begin
      act_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
      if (wrap_evt) begin
        act_ff <= nxt_last;
      end
    end
  end

  assign act_cmp = (link && act_ff) ? cmp1_ff : cmp0_ff;

  // compare against the value the counter is about to hold
  assign cmp_evt[0] = oc0 && tick && !clr_req && (nxt_cnt == act_cmp);
  assign cmp_evt[1] = oc1 && tick && !clr_req && (nxt_cnt == cmp1_ff);

  //////////////////////////////////////////////////////////////////////////////
  // pins

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_ff <= 2'h0;
      oe_ff <= 2'h0;
    end else if (!stop_mode) begin
      if (oc0) begin
        pin_ff[0] <= pin_step(pin_ff[0], ch_ff[0], wrap_evt, cmp_evt[0]);
      end
      if (oc1) begin
        pin_ff[1] <= pin_step(pin_ff[1], ch_ff[1], wrap_evt, cmp_evt[1]);
      end
      oe_ff[0] <= oc0 && ({ch_ff[0].level_select_hi, ch_ff[0].level_select_lo} != ELS_NONE);
      oe_ff[1] <= oc1 && ({ch_ff[1].level_select_hi, ch_ff[1].level_select_lo} != ELS_NONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags and interrupts

  assign nxt_wrap_st = flag_step(wrap_flag_ff, wrap_arm_ff, wrap_evt, acc_ok && tmr_ctl_rd,
                                 acc_ok && tmr_ctl_wr && !tmr_ctl_wdata.wrap_flag, flag_ok);
  assign nxt_ch0_st = flag_step(ch_flag_ff[0], ch_arm_ff[0], cmp_evt[0], acc_ok && chan_ctl_rd[0],
                                acc_ok && chan_ctl_wr[0] && !chan0_ctl_wdata.event_flag, flag_ok);
  assign nxt_ch1_st = flag_step(ch_flag_ff[1], ch_arm_ff[1], cmp_evt[1], acc_ok && chan_ctl_rd[1],
                                acc_ok && chan_ctl_wr[1] && !chan1_ctl_wdata.event_flag, flag_ok);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrap_flag_ff <= 1'b0;
      wrap_arm_ff <= 1'b0;
      ch_flag_ff <= 2'h0;
      ch_arm_ff <= 2'h0;
    end else begin
      {wrap_flag_ff, wrap_arm_ff} <= nxt_wrap_st;
      {ch_flag_ff[0], ch_arm_ff[0]} <= nxt_ch0_st;
      {ch_flag_ff[1], ch_arm_ff[1]} <= nxt_ch1_st;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrap_irq_ff <= 1'b0;
      ch_irq_ff <= 2'h0;
      wake_ff <= 1'b0;
    end else begin
      wrap_irq_ff <= nxt_wrap_st[1] && tmr_ff.wrap_irq_enable;
      ch_irq_ff[0] <= nxt_ch0_st[1] && ch_ff[0].irq_enable;
      ch_irq_ff[1] <= nxt_ch1_st[1] && ch_ff[1].irq_enable && !link;
      wake_ff <= (nxt_wrap_st[1] && tmr_ff.wrap_irq_enable)
                 || (nxt_ch0_st[1] && ch_ff[0].irq_enable)
                 || (nxt_ch1_st[1] && ch_ff[1].irq_enable && !link);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign tmr_ctl_q = {wrap_flag_ff, tmr_ff.wrap_irq_enable, tmr_ff.counter_halt, 1'b0,
                      tmr_ff.prescale_select};
  assign chan0_ctl_q = {ch_flag_ff[0], ch_ff[0][6:0]};
  assign chan1_ctl_q = {ch_flag_ff[1], ch_ff[1][6:0]};
  assign counter_q = cnt_ff;
  assign mod_q = mod_ff;
  assign cmp0_q = cmp0_ff;
  assign cmp1_q = cmp1_ff;
  assign chan0_pin_o = pin_ff[0];
  assign chan1_pin_o = pin_ff[1];
  assign chan0_pin_oe = oe_ff[0];
  assign chan1_pin_oe = oe_ff[1];
  assign wrap_irq = wrap_irq_ff;
  assign chan0_irq = ch_irq_ff[0];
  assign chan1_irq = ch_irq_ff[1];
  assign wake_req = wake_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wrap_restart: assert property (wrap_evt && !clr_req |=> cnt_ff == CNT_RST && wrap_flag_ff)
    else $error("counter did not restart at modulo");
  a_clear_zero: assert property (clr_req |=> cnt_ff == CNT_RST ##1 tmr_ctl_q.counter_clear == 1'b0)
    else $error("counter clear failed");
  a_halt_hold: assert property (tmr_ff.counter_halt && !clr_req |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while halted");
  a_stop_freeze: assert property (stop_mode |=> $stable(cnt_ff) && $stable(pin_ff) && $stable(mod_ff))
    else $error("state changed in stop mode");
  a_break_hold: assert property (break_state && !clr_req |=> $stable(cnt_ff))
    else $error("counter moved during break");
  a_break_flag: assert property (break_state && !break_clear_enable && wrap_flag_ff |=> wrap_flag_ff)
    else $error("flag cleared during protected break");
  a_wait_closed: assert property (wait_mode && cmp0_wr.wr |=> $stable(cmp0_ff))
    else $error("register written in wait mode");
  a_wrap_toggle: assert property (wrap_evt && oc0 && ch_ff[0].toggle_on_wrap && !cmp_evt[0]
                                  |=> pin_ff[0] != $past(pin_ff[0]))
    else $error("pin did not toggle at wrap");
  a_cmp_clear: assert property (cmp_evt[0] && !ch_ff[0].full_duty && !stop_mode
                                && {ch_ff[0].level_select_hi, ch_ff[0].level_select_lo} == ELS_CLEAR
                                |=> !pin_ff[0])
    else $error("compare did not clear pin");
  a_full_duty: assert property (oc0 && ch_ff[0].full_duty && !ch_ff[0].toggle_on_wrap && !stop_mode
                                |=> pin_ff[0] == !$past(ch_ff[0].level_select_lo))
    else $error("full duty level wrong");
  a_link_swap: assert property (link && wrap_evt |=> act_ff == $past(nxt_last))
    else $error("buffered pair not switched at wrap");
  a_wrap_irq: assert property (wrap_flag_ff && tmr_ff.wrap_irq_enable && !tmr_ctl_wr
                               |=> wrap_irq && wake_req)
    else $error("wrap interrupt missing");
  a_link_pin1: assert property (link |=> !chan1_pin_oe && !chan1_irq)
    else $error("channel 1 active while linked");

  c_wrap: cover property (wrap_evt ##1 wrap_irq);
  c_swap: cover property (link && cmp1_wr.wr ##[1:300] wrap_evt ##1 act_ff);
  c_full: cover property (ch_ff[0].full_duty && chan0_pin_o && chan0_pin_oe);
  c_brk_clr: cover property (break_state && break_clear_enable && wrap_flag_ff ##1 !wrap_flag_ff);

endmodule : tpc_pwm_pair
`default_nettype wire

// file: tb/tb_tpc_pwm_pair.sv
// self-checking bench for the two-channel pwm timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_tpc_pwm_pair
  import tpc_pkg::*;
;
  logic clk, rst, wait_mode, stop_mode, break_state, bce, trd, twr, ext, lvl;
  logic [1:0] crd, cwr;
  tpc_tmr_ctl_s tw_d, tq;
  tpc_chan_ctl_s cw_d, c0q, c1q;
  tpc_wr16_s mw, c0w, c1w;
  logic [15:0] cnt, modq, cmp0q, cmp1q, per, hi, c;
  logic p0o, p0e, p1o, p1e, wirq, c0irq, c1irq, wake;
  logic [1:0] ext_div;
  int bad_count, n_compared, z, cyc_n;

  tpc_pwm_pair DUT (.clk(clk), .rst(rst), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .break_state(break_state), .break_clear_enable(bce), .tmr_ctl_rd(trd), .tmr_ctl_wr(twr),
    .tmr_ctl_wdata(tw_d), .chan_ctl_rd(crd), .chan_ctl_wr(cwr), .chan0_ctl_wdata(cw_d),
    .chan1_ctl_wdata(cw_d), .mod_wr(mw), .cmp0_wr(c0w), .cmp1_wr(c1w), .ext_timer_clock_pin(ext),
    .tmr_ctl_q(tq), .chan0_ctl_q(c0q), .chan1_ctl_q(c1q), .counter_q(cnt), .mod_q(modq),
    .cmp0_q(cmp0q), .cmp1_q(cmp1q), .chan0_pin_o(p0o), .chan0_pin_oe(p0e), .chan1_pin_o(p1o),
    .chan1_pin_oe(p1e), .wrap_irq(wirq), .chan0_irq(c0irq), .chan1_irq(c1irq), .wake_req(wake));

  tpc_pin_load load (.clk(clk), .rst(rst), .pin_o(p0o), .pin_oe(p0e), .lvl(lvl), .per_ff(per),
    .hi_ff(hi));

  //////////////////////////////////////////////////////////////////////////////

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // external timer clock: one rising edge every four bus clocks
  always @(posedge clk) begin
    ext_div <= ext_div + 2'h1;
    ext <= ext_div[1];
  end

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic tw(input logic ie, input logic h, input logic cl, input logic [2:0] ps,
                    input logic f = 1'b1);
    @(posedge clk);
    tw_d <= tpc_tmr_ctl_s'{f, ie, h, cl, ps};
    twr <= 1'b1;
    @(posedge clk);
    twr <= 1'b0;
  endtask : tw

  task automatic rd_t;
    @(posedge clk);
    trd <= 1'b1;
    @(posedge clk);
    trd <= 1'b0;
  endtask : rd_t

  task automatic cw(input int ch, input logic [7:0] v);
    @(posedge clk);
    cw_d <= v;
    cwr[ch] <= 1'b1;
    @(posedge clk);
    cwr <= 2'h0;
  endtask : cw

  // k: 0 modulo, 1 channel-0 compare, 2 channel-1 compare
  task automatic ww(input int k, input logic [15:0] v);
    @(posedge clk);
    case (k)
      0: mw <= '{1'b1, v};
      1: c0w <= '{1'b1, v};
      default: c1w <= '{1'b1, v};
    endcase
    @(posedge clk);
    mw.wr <= 1'b0;
    c0w.wr <= 1'b0;
    c1w.wr <= 1'b0;
  endtask : ww

  // counts cycles, out of 300, where the loaded pin is not at level v
  task automatic off_lvl(input logic v);
    z = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (lvl !== v) z++;
    end
  endtask : off_lvl

  //////////////////////////////////////////////////////////////////////////////

  initial begin
    {rst, wait_mode, stop_mode, break_state, bce, trd, twr, crd, cwr, ext, ext_div} = '0;
    rst = 1'b1;
    tw_d = TMR_CTL_RST;
    cw_d = CHAN_CTL_RST;
    {mw, c0w, c1w} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(6);
    `CHK(tq, TMR_CTL_RST)
    `CHK(cnt, CNT_RST)
    `CHK(modq, MOD_RST)
    // halt, clear, modulo, compare, mode, then release
    tw(1'b0, 1'b1, 1'b1, PS_DIV1);
    ww(0, 16'h00ff);
    ww(1, 16'h0080);
    cw(0, 8'hda);
    tw(1'b1, 1'b0, 1'b0, PS_DIV1);
    cyc(800);
    `CHK(per, 16'h0100)
    `CHK(hi, 16'h0080)
    `CHK(tq.wrap_flag, 1'b1)
    `CHK(wirq, 1'b1)
    `CHK(c0q.event_flag, 1'b1)
    `CHK(c0irq, 1'b1)
    `CHK(wake, 1'b1)
    // break with flag protection, then with clears allowed
    @(posedge clk);
    break_state <= 1'b1;
    cyc(2);
    c = cnt;
    cyc(20);
    `CHK(cnt, c)
    rd_t();
    tw(1'b1, 1'b0, 1'b0, PS_DIV1, 1'b0);
    cyc(2);
    `CHK(tq.wrap_flag, 1'b1)
    @(posedge clk);
    bce <= 1'b1;
    rd_t();
    tw(1'b1, 1'b0, 1'b0, PS_DIV1, 1'b0);
    cyc(3);
    `CHK(tq.wrap_flag, 1'b0)
    `CHK(wirq, 1'b0)
    @(posedge clk);
    {break_state, bce} <= 2'h0;
    cyc(10);
    stop_mode <= 1'b1;
    cyc(2);
    c = cnt;
    cyc(30);
    `CHK(cnt, c)
    stop_mode <= 1'b0;
    cyc(3);
    `CHK(cnt !== c, 1'b1)
    tw(1'b1, 1'b1, 1'b1, PS_DIV1);
    cyc(2);
    `CHK(cnt, 16'h0000)
    `CHK(tq.counter_clear, 1'b0)
    tw(1'b1, 1'b0, 1'b0, PS_DIV1);
    // wait mode: accesses dropped while the counter keeps going
    wait_mode <= 1'b1;
    ww(0, 16'h0100);
    cyc(2);
    `CHK(modq, 16'h00ff)
    c = cnt;
    cyc(3);
    `CHK(cnt !== c, 1'b1)
    wait_mode <= 1'b0;
    // set on compare, then a shorter width written on the fly
    cw(0, 8'hde);
    ww(1, 16'h0040);
    cyc(800);
    `CHK(per, 16'h0100)
    `CHK(hi, 16'h00c0)
    cw(0, 8'hda);
    ww(1, 16'h0020);
    cyc(800);
    `CHK(hi, 16'h0020)
    cw(0, 8'hd8);
    cyc(300);
    off_lvl(1'b0);
    `CHK(z, 0)
    cw(0, 8'hd9);
    cyc(10);
    off_lvl(1'b1);
    `CHK(z, 0)
    // prescaler: divide by 2, then the external clock pin
    cw(0, 8'hda);
    ww(1, 16'h0080);
    tw(1'b1, 1'b0, 1'b0, 3'h1);
    cyc(2000);
    `CHK(per, 16'h0200)
    `CHK(hi, 16'h0100)
    tw(1'b1, 1'b0, 1'b0, PS_EXT);
    cyc(3500);
    `CHK(per, 16'h0400)
    // buffered: link bit wins over the unbuffered bit
    tw(1'b1, 1'b0, 1'b0, PS_DIV1);
    cw(0, 8'hfa);
    cyc(800);
    `CHK(hi, 16'h0080)
    ww(2, 16'h0040);
    cyc(800);
    `CHK(hi, 16'h0040)
    cw(1, 8'hda);
    cyc(4);
    `CHK(p1e, 1'b0)
    `CHK(p1o, 1'b0)
    `CHK(c1irq, 1'b0)
    `CHK(c1q, 8'h5a)
    `CHK(cmp1q, 16'h0040)
    ww(1, 16'h0020);
    cyc(800);
    `CHK(cmp0q, 16'h0020)
    `CHK(hi, 16'h0020)
    `CHK(per, 16'h0100)
    test_done();
  end
endmodule : tb_tpc_pwm_pair
`default_nettype wire

// file: tb/tpc_pin_load.sv
// external load on a channel pin: pull-down plus period and high-time meter
`timescale 1ns/100ps
`default_nettype none
module tpc_pin_load (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin as driven by the timer
  input wire logic pin_o,
  input wire logic pin_oe,
  // measurements
  output logic lvl,
  output logic [15:0] per_ff,
  output logic [15:0] hi_ff
);
  logic lst_ff;
  logic [15:0] pcnt_ff;
  logic [15:0] hcnt_ff;

  // pull-down, so a released pin reads low instead of keeping its last level
  assign lvl = pin_oe ? pin_o : 1'b0;

  //////////////////////////////////////////////////////////////////////////////

  // one window runs from a rising edge up to the next one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lst_ff <= 1'b0;
      pcnt_ff <= 16'h0000;
      hcnt_ff <= 16'h0000;
      per_ff <= 16'h0000;
      hi_ff <= 16'h0000;
    end else begin
      lst_ff <= lvl;
      if (lvl && !lst_ff) begin
        per_ff <= pcnt_ff;
        hi_ff <= hcnt_ff;
        pcnt_ff <= 16'h0001;
        hcnt_ff <= 16'h0001;
      end else begin
        pcnt_ff <= pcnt_ff + 16'h0001;
        hcnt_ff <= hcnt_ff + {15'h0000, lvl};
      end
    end
  end
endmodule : tpc_pin_load
`default_nettype wire
